// >>> tb/mbrad_master.sv
// Behavioural remote master issuing register requests to the decoder
`timescale 1ns/1ns
module mbrad_master
(
  input  wire logic        clk,
  output logic             req_valid,
  output logic [7:0]       req_fc,
  output logic [15:0]      rd_addr,
  output logic [15:0]      rd_count,
  output logic [15:0]      wr_addr,
  output logic [15:0]      wr_count
);
  initial
  begin
    req_valid = 1'b0;
    req_fc    = 8'h00;
    rd_addr   = 16'h0000;
    rd_count  = 16'h0000;
    wr_addr   = 16'h0000;
    wr_count  = 16'h0000;
  end

  // Valid stays up across calls so requests can follow on every edge
  task automatic send(input logic [7:0] fc, input logic [15:0] ra, rc, wa, wc);
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_fc    = fc;
    rd_addr   = ra;
    rd_count  = rc;
    wr_addr   = wa;
    wr_count  = wc;
  endtask

  // Released lines show the inverse so a stale request never looks live
  task automatic release_bus();
    @(posedge clk);
    #1;
    req_valid = 1'b0;
    req_fc    = ~req_fc;
    rd_addr   = ~rd_addr;
    rd_count  = ~rd_count;
    wr_addr   = ~wr_addr;
    wr_count  = ~wr_count;
  endtask
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the register address decoder
`timescale 1ns/1ns
module tb_top
  import mbrad_pkg::*;
;
  logic        clk;
  logic        nrst;
  logic [15:0] flag_words;
  logic        req_valid;
  logic [7:0]  req_fc;
  logic [15:0] rd_addr;
  logic [15:0] rd_count;
  logic [15:0] wr_addr;
  logic [15:0] wr_count;
  logic        rsp_valid;
  logic [7:0]  rsp_exc;
  logic        rd_en;
  logic [2:0]  rd_area;
  logic [15:0] rd_index;
  logic        wr_en;
  logic [2:0]  wr_area;
  logic [15:0] wr_index;
  logic [31:0] seed;
  logic [15:0] r;
  logic [47:0] expq[$];
  int          err_count;
  int          cmp_count;
  localparam logic [47:0] EXC = {MBRAD_EXC_ADDR, 40'h0};

  mbrad_master i_mbrad_master (.clk(clk), .req_valid(req_valid), .req_fc(req_fc),
    .rd_addr(rd_addr), .rd_count(rd_count), .wr_addr(wr_addr), .wr_count(wr_count));

  mbrad_decoder i_mbrad_decoder (.clk(clk), .nrst(nrst), .req_valid(req_valid),
    .req_fc(req_fc), .rd_addr(rd_addr), .rd_count(rd_count), .wr_addr(wr_addr),
    .wr_count(wr_count), .flag_words(flag_words), .rsp_valid(rsp_valid),
    .rsp_exc(rsp_exc), .rd_en(rd_en), .rd_area(rd_area), .rd_index(rd_index),
    .wr_en(wr_en), .wr_area(wr_area), .wr_index(wr_index));

  initial clk = 1'b0;
  always #2 clk = ~clk;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [47:0] rdx(logic [2:0] a, logic [15:0] i);
    return {8'h00, 1'b1, a, i, 1'b0, 3'h0, 16'h0000};
  endfunction

  function automatic logic [47:0] wrx(logic [2:0] a, logic [15:0] i);
    return {8'h00, 1'b0, 3'h0, 16'h0000, 1'b1, a, i};
  endfunction

  // Area and index only mean something while their enable is up
  function automatic logic [47:0] seen();
    return {rsp_exc, rd_en, rd_en === 1'b1 ? rd_area : 3'h0,
      rd_en === 1'b1 ? rd_index : 16'h0000, wr_en, wr_en === 1'b1 ? wr_area : 3'h0,
      wr_en === 1'b1 ? wr_index : 16'h0000};
  endfunction

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic req(input logic [7:0] fc, input logic [15:0] ra, rc, wa, wc,
                     input logic [47:0] e);
    i_mbrad_master.send(fc, ra, rc, wa, wc);
    expq.push_back(e);
  endtask

  task automatic rd(input logic [7:0] fc, input logic [15:0] a, n, input logic [47:0] e);
    req(fc, a, n, 16'h0000, 16'h0000, e);
  endtask

  task automatic wr(input logic [7:0] fc, input logic [15:0] a, n, input logic [47:0] e);
    req(fc, 16'h0000, 16'h0000, a, n, e);
  endtask

  task automatic end_test(input string name);
    int n;
    n = 0;
    i_mbrad_master.release_bus();
    while (expq.size() != 0 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    if (expq.size() != 0)
    begin
      err_count++;
      $display("unexpected at %0t: response missing in %s", $time, name);
      expq.delete();
    end
    $display("test %s done", name);
  endtask

  task automatic conclude();
    $display("compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(negedge clk)
  begin
    if (rsp_valid !== 1'b0)
    begin
      if (expq.size() == 0)
      begin
        err_count++;
        $display("unexpected at %0t: response without request", $time);
      end
      else
        check(seen(), expq.pop_front());
    end
  end

  initial
  begin
    #20000;
    err_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    conclude();
  end

  initial
  begin
    nrst = 1'b0;
    flag_words = 16'h3000;
    seed = 32'h00000043;
    err_count = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge clk);
    rd(MBRAD_FC_RD_HOLD, 16'h0005, 16'h0002, rdx(MBRAD_AREA_IN, 16'h0005));
    rd(MBRAD_FC_RD_INPUT, 16'h03e7, 16'h0001, rdx(MBRAD_AREA_IN, 16'h03e7));
    rd(MBRAD_FC_RD_HOLD, 16'h03e8, 16'h0001, rdx(MBRAD_AREA_OUT, 16'h0000));
    rd(MBRAD_FC_RD_INPUT, 16'h07cf, 16'h0001, rdx(MBRAD_AREA_OUT, 16'h03e7));
    req(MBRAD_FC_RDWR, 16'h03e8, 16'h0001, 16'h03e8, 16'h0001,
        rdx(MBRAD_AREA_OUT, 16'h0000));
    req(MBRAD_FC_RDWR, 16'h0010, 16'h0001, 16'h0020, 16'h0001,
        rdx(MBRAD_AREA_IN, 16'h0010) | wrx(MBRAD_AREA_IN, 16'h0020));
    i_mbrad_master.send(8'h01, 16'h0000, 16'h0001, 16'h0000, 16'h0001);
    rd(MBRAD_FC_RD_HOLD, 16'h07cf, 16'h0002, EXC);
    rd(MBRAD_FC_RD_INPUT, 16'h07d0, 16'h0001, EXC);
    rd(MBRAD_FC_RD_HOLD, 16'h0fff, 16'h0001, EXC);
    end_test("images");
    rd(MBRAD_FC_RD_INPUT, 16'h1022, 16'h0001, rdx(MBRAD_AREA_INFO, 16'h1022));
    rd(MBRAD_FC_RD_HOLD, 16'h1026, 16'h0001, EXC);
    wr(MBRAD_FC_WR_SINGLE, 16'h1050, 16'h0001, EXC);
    req(MBRAD_FC_RDWR, 16'h1040, 16'h0001, 16'h1037, 16'h0001,
        rdx(MBRAD_AREA_INFO, 16'h1040) | wrx(MBRAD_AREA_INFO, 16'h1037));
    req(MBRAD_FC_RDWR, 16'h1040, 16'h0001, 16'h1022, 16'h0001,
        rdx(MBRAD_AREA_INFO, 16'h1040));
    wr(MBRAD_FC_MASK_WR, 16'h1030, 16'h0001, EXC);
    wr(MBRAD_FC_WR_SINGLE, 16'h1030, 16'h0001, wrx(MBRAD_AREA_INFO, 16'h1030));
    wr(MBRAD_FC_WR_MULTI, 16'h1100, 16'h0001, wrx(MBRAD_AREA_INFO, 16'h1100));
    wr(MBRAD_FC_WR_MULTI, 16'h1022, 16'h0001, 48'h0);
    end_test("info");
    wr(MBRAD_FC_WR_SINGLE, 16'h03e8, 16'h0001, EXC);
    wr(MBRAD_FC_WR_MULTI, 16'h0fff, 16'h0001, EXC);
    wr(MBRAD_FC_WR_MULTI, 16'h03e6, 16'h0003, EXC);
    wr(MBRAD_FC_MASK_WR, 16'h0003, 16'h0001, wrx(MBRAD_AREA_IN, 16'h0003));
    for (int k = 0; k < 12; k++)
    begin
      r = 16'(rnd() % 1000);
      rd(MBRAD_FC_RD_HOLD, r + 16'h03e8, 16'h0001, rdx(MBRAD_AREA_OUT, r));
      wr(MBRAD_FC_WR_SINGLE, r, 16'h0001, wrx(MBRAD_AREA_IN, r));
    end
    end_test("writes");
    rd(MBRAD_FC_RD_HOLD, 16'h5fff, 16'h0001, rdx(MBRAD_AREA_FLAG, 16'h2fff));
    wr(MBRAD_FC_WR_MULTI, 16'h3000, 16'h0002, wrx(MBRAD_AREA_FLAG, 16'h0000));
    rd(MBRAD_FC_RD_INPUT, 16'h6000, 16'h0001, EXC);
    end_test("flags");
    #1;
    flag_words = 16'h0010;
    // Size must pass the synchroniser and the agreement stage first
    repeat (6) @(posedge clk);
    rd(MBRAD_FC_RD_HOLD, 16'h300f, 16'h0001, rdx(MBRAD_AREA_FLAG, 16'h000f));
    rd(MBRAD_FC_RD_HOLD, 16'h300f, 16'h0002, EXC);
    wr(MBRAD_FC_WR_SINGLE, 16'h3010, 16'h0001, EXC);
    end_test("flag size");
    conclude();
  end
endmodule

// >>> verilog/mbrad_decoder.sv
// Register service address decoder: routes one request per cycle
// Overview of operation
// - Reads at 0..999 return words of the 1000-word input process image.
// - Reads at 1000..1999 return words of the 1000-word output process image.
// - A combined read/write at 1000..1999 performs only its read part.
// - Reads touching 2000..4095 are refused with exception 0x02.
// - Addresses 4096..12287 decode as the info/config space, partly implemented.
// - Any access whose first word is an unimplemented info/config address gets exception 0x02, bar a combined write whose read is in the output image.
// - The write part of a combined read/write in info space hits only writable registers.
// - Addresses 12288..65535 map onto flag words from word zero, at most 53248.
// - Writes at 0..999 update words of the input process image.
// - Writes touching 1000..4095 get exception 0x02 and modify nothing; a combined write whose read is in the output image is dropped instead.
// - Mask write is never executed against the info/config space.
// - Info/config writes by single, multiple or combined service hit writable ones only.
// - Info/config space is read by 3, 4, 23 and written by 6, 16, 23 only.
`timescale 1ns/1ns
module mbrad_decoder
  import mbrad_pkg::*;
#(
  parameter logic [15:0] FLAG_WORDS = MBRAD_FLAG_DEFAULT
)
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        req_valid,
  input  wire logic [7:0]  req_fc,
  input  wire logic [15:0] rd_addr,
  input  wire logic [15:0] rd_count,
  input  wire logic [15:0] wr_addr,
  input  wire logic [15:0] wr_count,
  input  wire logic [15:0] flag_words,
  output logic             rsp_valid,
  output logic [7:0]       rsp_exc,
  output logic             rd_en,
  output mbrad_area_t      rd_area,
  output logic [15:0]      rd_index,
  output logic             wr_en,
  output mbrad_area_t      wr_area,
  output logic [15:0]      wr_index
);
  logic        rst_meta;
  logic        rst_sync;
  logic [15:0] flag_meta;
  logic [15:0] flag_sync;
  logic [15:0] flag_prev;
  logic [15:0] flag_size;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Flag size comes from the memory arrangement, another domain
  // A word is taken only once two synchronised samples agree, so a bus
  // caught mid-change never lands as a mix of old and new bits
  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      flag_meta <= FLAG_WORDS;
      flag_sync <= FLAG_WORDS;
      flag_prev <= FLAG_WORDS;
      flag_size <= FLAG_WORDS;
    end
    else
    begin
      flag_meta <= flag_words;
      flag_sync <= flag_meta;
      flag_prev <= flag_sync;
      if (flag_sync == flag_prev)
        flag_size <= flag_prev;
    end
  end

  logic        is_rd;
  logic        is_wr;
  logic        is_mask;
  logic        is_rdwr;
  logic [16:0] rd_last;
  logic [16:0] wr_last;
  logic        rd_ok;
  logic        wr_ok;
  logic        wr_do;
  mbrad_area_t next_rd_area;
  mbrad_area_t next_wr_area;
  logic [15:0] next_rd_index;
  logic [15:0] next_wr_index;
  logic        rd_info_v;
  logic        rd_info_w;
  logic        wr_info_v;
  logic        wr_info_w;
  logic [15:0] flag_lim;

  mbrad_info_map u_rd_map
  (
    .addr     (rd_addr),
    .valid    (rd_info_v),
    .writable (rd_info_w)
  );

  mbrad_info_map u_wr_map
  (
    .addr     (wr_addr),
    .valid    (wr_info_v),
    .writable (wr_info_w)
  );

  assign is_rd   = (req_fc == MBRAD_FC_RD_HOLD) || (req_fc == MBRAD_FC_RD_INPUT)
                   || (req_fc == MBRAD_FC_RDWR);
  assign is_mask = (req_fc == MBRAD_FC_MASK_WR);
  assign is_rdwr = (req_fc == MBRAD_FC_RDWR);
  assign is_wr   = (req_fc == MBRAD_FC_WR_SINGLE) || (req_fc == MBRAD_FC_WR_MULTI)
                   || is_mask || is_rdwr;
  // Last word touched; a zero count is treated as a single word
  assign rd_last = {1'b0, rd_addr} + {1'b0, rd_count} - 17'(rd_count != 16'h0000);
  assign wr_last = {1'b0, wr_addr} + {1'b0, wr_count} - 17'(wr_count != 16'h0000);
  // Configured size is capped at the largest flag area
  assign flag_lim = (flag_size > MBRAD_FLAG_MAX) ? MBRAD_FLAG_MAX : flag_size;

  // Read side: whole range must sit in one permitted area
  always_comb
  begin
    next_rd_area  = MBRAD_AREA_NONE;
    next_rd_index = 16'h0000;
    rd_ok         = 1'b0;
    if (rd_last[16])
      rd_ok = 1'b0;
    else if (rd_last[15:0] <= MBRAD_IN_IMG_HI)
    begin
      next_rd_area  = MBRAD_AREA_IN;
      next_rd_index = rd_addr - MBRAD_IN_IMG_LO;
      rd_ok         = 1'b1;
    end
    else if (rd_addr >= MBRAD_OUT_IMG_LO && rd_last[15:0] <= MBRAD_OUT_IMG_HI)
    begin
      next_rd_area  = MBRAD_AREA_OUT;
      next_rd_index = rd_addr - MBRAD_OUT_IMG_LO;
      rd_ok         = 1'b1;
    end
    else if (rd_addr >= MBRAD_INFO_LO && rd_last[15:0] <= MBRAD_INFO_HI)
    begin
      // Only the first word is checked against the table
      next_rd_area  = MBRAD_AREA_INFO;
      next_rd_index = rd_addr;
      rd_ok         = rd_info_v;
    end
    else if (rd_addr >= MBRAD_FLAG_LO)
    begin
      next_rd_area  = MBRAD_AREA_FLAG;
      next_rd_index = rd_addr - MBRAD_FLAG_LO;
      rd_ok         = (rd_last[15:0] - MBRAD_FLAG_LO) < flag_lim;
    end
    // Anything touching the inhibited band falls through refused
  end

  // Write side
  always_comb
  begin
    next_wr_area  = MBRAD_AREA_NONE;
    next_wr_index = 16'h0000;
    wr_ok         = 1'b0;
    if (wr_last[16])
      wr_ok = 1'b0;
    else if (wr_last[15:0] <= MBRAD_IN_IMG_HI)
    begin
      next_wr_area  = MBRAD_AREA_IN;
      next_wr_index = wr_addr - MBRAD_IN_IMG_LO;
      wr_ok         = 1'b1;
    end
    else if (wr_addr >= MBRAD_INFO_LO && wr_last[15:0] <= MBRAD_INFO_HI)
    begin
      next_wr_area  = MBRAD_AREA_INFO;
      next_wr_index = wr_addr;
      wr_ok         = wr_info_v && !is_mask;
    end
    else if (wr_addr >= MBRAD_FLAG_LO)
    begin
      next_wr_area  = MBRAD_AREA_FLAG;
      next_wr_index = wr_addr - MBRAD_FLAG_LO;
      wr_ok         = (wr_last[15:0] - MBRAD_FLAG_LO) < flag_lim;
    end
    // Output image and inhibited band are refused here
  end

  // Combined service in the output image keeps its read and drops its write
  logic rdwr_out_rd;
  logic req_ok;
  logic wr_skip;
  assign rdwr_out_rd = is_rdwr && next_rd_area == MBRAD_AREA_OUT && rd_ok;
  assign wr_skip     = is_rdwr && (rdwr_out_rd || (wr_ok && next_wr_area == MBRAD_AREA_INFO
                       && !wr_info_w));
  assign req_ok      = (!is_rd || rd_ok) && (!is_wr || wr_ok || rdwr_out_rd);
  // Read-only info registers silently ignore single and multiple writes
  assign wr_do       = is_wr && wr_ok && !wr_skip
                       && !(next_wr_area == MBRAD_AREA_INFO && !wr_info_w);

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      rsp_valid <= 1'b0;
      rsp_exc   <= MBRAD_EXC_NONE;
      rd_en     <= 1'b0;
      wr_en     <= 1'b0;
      rd_area   <= MBRAD_AREA_NONE;
      wr_area   <= MBRAD_AREA_NONE;
      rd_index  <= 16'h0000;
      wr_index  <= 16'h0000;
    end
    else
    begin
      rsp_valid <= req_valid && (is_rd || is_wr);
      rsp_exc   <= (req_valid && (is_rd || is_wr) && !req_ok) ? MBRAD_EXC_ADDR
                                                              : MBRAD_EXC_NONE;
      rd_en     <= req_valid && is_rd && req_ok;
      wr_en     <= req_valid && req_ok && wr_do;
      rd_area   <= next_rd_area;
      wr_area   <= next_wr_area;
      rd_index  <= next_rd_index;
      wr_index  <= next_wr_index;
    end
  end

  sequence rdwr_out_req_s;
    req_valid && is_rdwr && next_rd_area == MBRAD_AREA_OUT && rd_ok;
  endsequence

  out_rdwr_a: assert property (@(posedge clk) disable iff (!rst_sync)
    rdwr_out_req_s |=> rd_en && !wr_en && rsp_exc == MBRAD_EXC_NONE)
    else $error("combined access in output image wrote or failed");
  inhib_read_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && is_rd && rd_addr >= MBRAD_INHIB_LO && rd_addr <= MBRAD_INHIB_HI
    |=> rsp_exc == MBRAD_EXC_ADDR && !rd_en)
    else $error("read of inhibited band not refused");
  inhib_write_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && (req_fc == MBRAD_FC_WR_SINGLE) && wr_addr >= MBRAD_OUT_IMG_LO
    && wr_addr <= MBRAD_INHIB_HI |=> !wr_en && rsp_exc == MBRAD_EXC_ADDR)
    else $error("write into inhibited band accepted");
  in_write_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && (req_fc == MBRAD_FC_WR_SINGLE) && wr_addr <= MBRAD_IN_IMG_HI
    |=> wr_en && wr_area == MBRAD_AREA_IN && wr_index == $past(wr_addr))
    else $error("input image write not routed");
  mask_info_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && is_mask && wr_addr >= MBRAD_INFO_LO && wr_addr <= MBRAD_INFO_HI
    |=> !wr_en && rsp_exc == MBRAD_EXC_ADDR)
    else $error("mask write reached info space");
  info_bad_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && is_rd && rd_addr >= MBRAD_INFO_LO && rd_addr <= MBRAD_INFO_HI
    && !rd_info_v |=> rsp_exc == MBRAD_EXC_ADDR)
    else $error("unimplemented info address answered");
  ro_write_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && is_wr && next_wr_area == MBRAD_AREA_INFO && !wr_info_w |=> !wr_en)
    else $error("read-only info register written");
  flag_map_a: assert property (@(posedge clk) disable iff (!rst_sync)
    rd_en && rd_area == MBRAD_AREA_FLAG |-> rd_index == $past(rd_addr) - MBRAD_FLAG_LO)
    else $error("flag word index wrong");
  flag_limit_a: assert property (@(posedge clk) disable iff (!rst_sync)
    rd_en && rd_area == MBRAD_AREA_FLAG |-> rd_index < flag_lim)
    else $error("flag read beyond configured size");
  flag_wlimit_a: assert property (@(posedge clk) disable iff (!rst_sync)
    wr_en && wr_area == MBRAD_AREA_FLAG |-> wr_index < flag_lim)
    else $error("flag write beyond configured size");

  // A refusal answers with the exception and leaves both memories alone
  sequence refused_s;
    rsp_exc == MBRAD_EXC_ADDR && !rd_en && !wr_en;
  endsequence

  // Combined service whose write target is a read-only info register
  sequence rdwr_ro_req_s;
    req_valid && is_rdwr && rd_ok && next_wr_area == MBRAD_AREA_INFO && wr_info_v
    && !wr_info_w;
  endsequence

  out_write_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && is_wr && !is_rdwr && wr_addr >= MBRAD_OUT_IMG_LO
    && wr_addr <= MBRAD_INHIB_HI |=> refused_s)
    else $error("write into output image or inhibited band accepted");
  refuse_quiet_a: assert property (@(posedge clk) disable iff (!rst_sync)
    rsp_valid && rsp_exc == MBRAD_EXC_ADDR |-> !rd_en && !wr_en)
    else $error("refused request still touched memory");
  rdwr_ro_a: assert property (@(posedge clk) disable iff (!rst_sync)
    rdwr_ro_req_s |=> rd_en && !wr_en && rsp_exc == MBRAD_EXC_NONE)
    else $error("combined write reached read-only info register");
  in_read_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && req_fc == MBRAD_FC_RD_HOLD && rd_count == 16'h0001
    && rd_addr <= MBRAD_IN_IMG_HI
    |=> rd_en && rd_area == MBRAD_AREA_IN && rd_index == $past(rd_addr))
    else $error("input image read not routed");
  out_read_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && req_fc == MBRAD_FC_RD_HOLD && rd_count == 16'h0001
    && rd_addr >= MBRAD_OUT_IMG_LO && rd_addr <= MBRAD_OUT_IMG_HI
    |=> rd_en && rd_area == MBRAD_AREA_OUT
    && rd_index == $past(rd_addr) - MBRAD_OUT_IMG_LO)
    else $error("output image read not routed");
  info_write_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && req_fc == MBRAD_FC_WR_SINGLE && next_wr_area == MBRAD_AREA_INFO
    && wr_info_v && wr_info_w
    |=> wr_en && wr_area == MBRAD_AREA_INFO && wr_index == $past(wr_addr))
    else $error("writable info register not written");
  mask_in_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && is_mask && wr_count <= 16'h0001 && wr_addr <= MBRAD_IN_IMG_HI
    |=> wr_en && wr_area == MBRAD_AREA_IN)
    else $error("mask write into input image not routed");
  // Every register service gets exactly one answer, anything else none
  rsp_follow_a: assert property (@(posedge clk) disable iff (!rst_sync)
    req_valid && (is_rd || is_wr) |=> rsp_valid)
    else $error("register request left unanswered");
  fc_ignore_a: assert property (@(posedge clk) disable iff (!rst_sync)
    !req_valid || !(is_rd || is_wr) |=> !rsp_valid && !rd_en && !wr_en)
    else $error("answer without a register request");
endmodule

// >>> verilog/mbrad_info_map.sv
// Implemented information and configuration register table
`timescale 1ns/1ns
module mbrad_info_map
  import mbrad_pkg::*;
(
  input  wire logic [15:0] addr,
  output logic             valid,
  output logic             writable
);
  // Pure lookup, registered by the caller
  always_comb
  begin
    valid    = 1'b1;
    writable = MBRAD_INFO_RO;
    unique case (addr)
      16'h1022, 16'h1023, 16'h1024, 16'h1025, 16'h1028, 16'h102a,
      16'h1031, 16'h1032, 16'h1033, 16'h1040, 16'h1101:
        writable = MBRAD_INFO_RO;
      16'h1030, 16'h1037, 16'h1100, 16'h1102, 16'h1103, 16'h1104:
        writable = MBRAD_INFO_RW;
      16'h2000, 16'h2001, 16'h2002, 16'h2003, 16'h2004, 16'h2005,
      16'h2006, 16'h2007, 16'h2008, 16'h2010, 16'h2011, 16'h2012,
      16'h2013, 16'h2014, 16'h2015:
        writable = MBRAD_INFO_RO;
      default:
        valid = 1'b0;
    endcase
  end
endmodule

// >>> verilog/mbrad_pkg.sv
// Constants shared by the register address decoder
package mbrad_pkg;
  localparam logic [15:0] MBRAD_IN_IMG_LO    = 16'h0000;
  localparam logic [15:0] MBRAD_IN_IMG_HI    = 16'h03e7;
  localparam logic [15:0] MBRAD_OUT_IMG_LO   = 16'h03e8;
  localparam logic [15:0] MBRAD_OUT_IMG_HI   = 16'h07cf;
  localparam logic [15:0] MBRAD_INHIB_LO     = 16'h07d0;
  localparam logic [15:0] MBRAD_INHIB_HI     = 16'h0fff;
  localparam logic [15:0] MBRAD_INFO_LO      = 16'h1000;
  localparam logic [15:0] MBRAD_INFO_HI      = 16'h2fff;
  localparam logic [15:0] MBRAD_FLAG_LO      = 16'h3000;
  localparam logic [15:0] MBRAD_FLAG_MAX     = 16'hd000;
  localparam logic [15:0] MBRAD_FLAG_DEFAULT = 16'h3000;
  localparam logic [7:0]  MBRAD_EXC_NONE     = 8'h00;
  localparam logic [7:0]  MBRAD_EXC_ADDR     = 8'h02;
  localparam logic [7:0]  MBRAD_FC_RD_HOLD   = 8'h03;
  localparam logic [7:0]  MBRAD_FC_RD_INPUT  = 8'h04;
  localparam logic [7:0]  MBRAD_FC_WR_SINGLE = 8'h06;
  localparam logic [7:0]  MBRAD_FC_WR_MULTI  = 8'h10;
  localparam logic [7:0]  MBRAD_FC_MASK_WR   = 8'h16;
  localparam logic [7:0]  MBRAD_FC_RDWR      = 8'h17;
  localparam logic        MBRAD_INFO_RO      = 1'b0;
  localparam logic        MBRAD_INFO_RW      = 1'b1;

  typedef enum logic [2:0]
  {
    MBRAD_AREA_NONE  = 3'b000,
    MBRAD_AREA_IN    = 3'b001,
    MBRAD_AREA_OUT   = 3'b010,
    MBRAD_AREA_INFO  = 3'b011,
    MBRAD_AREA_FLAG  = 3'b100
  } mbrad_area_t;
endpackage
